// >>> scp_pkg.sv
// constants, field positions and types of the serial control port
// assumes: one system clock, link pins sampled through synchronisers
package scp_pkg;

  // instruction word layout
  localparam int INSTR_W = 16;              // two-byte instruction only
  localparam int BYTE_W = 8;                // data unit on the link
  localparam int ADDR_W = 13;               // start address width
  localparam int INSTR_RW_POS = 15;         // instruction_top_bit
  localparam int INSTR_LEN_HI = 14;         // length_field_high
  localparam int INSTR_LEN_LO = 13;         // length_field_low
  localparam int BIT_CNT_W = 4;             // counts up to 16 edges
  localparam logic [BIT_CNT_W-1:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [BIT_CNT_W-1:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [2:0] BYTE_PHASE_ZERO = 3'h0;

  // transfer length codes
  localparam logic [1:0] LEN_STREAM = 2'h3; // open-ended stream

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_READBACK = 13'h0004;
  localparam logic [ADDR_W-1:0] ADDR_UPDATE = 13'h0005;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;

  // reset values
  localparam logic [7:0] PORT_CFG_RESET = 8'h18;
  localparam logic [7:0] READBACK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // field positions
  localparam int CFG_LSB_HI = 6;            // bit-order copy, upper
  localparam int CFG_SOFT_RST = 5;          // self-clearing soft reset
  localparam int CFG_DEV_RST = 2;           // device reset request
  localparam int CFG_LSB_LO = 1;            // bit-order copy, lower
  localparam int READBACK_SEL = 0;          // read shadow copies
  localparam int UPDATE_BIT = 0;            // shadow to active strobe

  // serial engine states, one-hot
  typedef enum logic [2:0] {
    ST_INSTR = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b100
  } scp_state_t;

endpackage

// >>> scp_link_if.sv
// carrier for the synchronised link pins and their edge pulses
// assumes: produced and consumed on clk_sys only
`timescale 1ns/1ps
`default_nettype none

interface scp_link_if;
  logic cs_n;       // synchronised select, active low
  logic sdio_in;    // synchronised data line level
  logic sclk_rise;  // one-cycle pulse on shift-clock rising edge
  logic sclk_fall;  // one-cycle pulse on shift-clock falling edge

  // the synchroniser drives, the engine listens
  modport sync_side (output cs_n, output sdio_in, output sclk_rise,
                     output sclk_fall);
  modport engine_side (input cs_n, input sdio_in, input sclk_rise,
                       input sclk_fall);
endinterface

`default_nettype wire

// >>> scp_pin_sync.sv
// two-stage synchronisers for the link pins plus shift-clock edge finder
// assumes: pins are asynchronous to clk_sys; clk_sys well above sclk
`timescale 1ns/1ps
`default_nettype none

module scp_pin_sync
#(
  parameter int STAGES = 2  // synchroniser depth
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic sdio_pin,
  // synchronised view
  scp_link_if.sync_side lk
);

  localparam int NPIN = 3;  // sclk, select, data

  // an edge finder needs at least a two-flop chain ahead of it
  if (STAGES < 2)
  begin : g_bad_depth
    $error("scp_pin_sync: STAGES must be at least 2");
  end

  logic [NPIN-1:0] pins;        // raw pin vector
  logic [NPIN-1:0] synced;      // last synchroniser stage
  logic sclk_prev_reg;          // delayed sclk for edge detection

  assign pins = {sdio_pin, cs_n_pin, sclk_pin};

  // one chain per pin; only the final stage is read outside the chain
  for (genvar i = 0; i < NPIN; i++)
  begin : g_chain
    logic [STAGES-1:0] chain_reg;  // chain_reg[0] is the metastable flop
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        // select idles high so the port starts deselected
        chain_reg <= (i == 1) ? '1 : '0;
      end
      else
      begin
        chain_reg <= {chain_reg[STAGES-2:0], pins[i]};
      end
    end
    assign synced[i] = chain_reg[STAGES-1];
  end

  // previous shift-clock level, taken from the settled stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= synced[0];
    end
  end

  // data and select share the sclk delay, so edges line up with data
  assign lk.sclk_rise = synced[0] & ~sclk_prev_reg;
  assign lk.sclk_fall = ~synced[0] & sclk_prev_reg;
  assign lk.cs_n = synced[1];
  assign lk.sdio_in = synced[2];

endmodule // scp_pin_sync

`default_nettype wire

// >>> scp_serial_port.sv
// three-wire serial control port: instruction decode, shift engine,
// buffered port registers with shadow and active copies
// assumes: host drives sclk well below clk_sys/4; one shared data pin
`timescale 1ns/1ps
`default_nettype none

module scp_serial_port
  import scp_pkg::*;
#(
  parameter int SYNC_STAGES = 2  // pin synchroniser depth
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // active settings seen by the rest of the chip
  output logic lsb_first_active,
  output logic readback_shadow_active,
  output logic device_reset_req,
  output logic update_pulse
);

  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("scp_serial_port: SYNC_STAGES must be at least 2");
  end

  // all block state in one record
  typedef struct packed {
    scp_state_t fsm;                 // serial engine phase
    logic [BIT_CNT_W-1:0] bit_cnt;   // rising edges in current unit
    logic [INSTR_W-1:0] rx;          // incoming shift register
    logic is_read;                   // direction of current cycle
    logic stream;                    // open-ended transfer
    logic [1:0] bytes_left;          // fixed-length bytes due after the current one
    logic [ADDR_W-1:0] addr;         // internal address counter
    logic [BYTE_W-1:0] tx;           // outgoing shift register
    logic sdio_out;                  // launched read bit
    logic sdio_oe;                   // drive enable for data line
    logic [7:0] cfg_shadow;          // port config, buffered copy
    logic [7:0] cfg_active;          // port config, copy in use
    logic rb_shadow;                 // readback select, buffered
    logic rb_active;                 // readback select, in use
    logic update_pulse;              // one cycle on each update
  } scp_regs_t;

  scp_regs_t r_reg;   // registered state
  scp_regs_t r_next;  // next state

  scp_link_if lk();   // synchronised pins

  // pin synchronisers and sclk edge finder
  scp_pin_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .sclk_pin(sclk),
    .cs_n_pin(cs_n),
    .sdio_pin(sdio_in),
    .lk(lk)
  );

  // mirror the two bit-order copies and force the fixed bits
  function automatic logic [7:0] cfg_from_byte(input logic [7:0] b);
    logic [7:0] c;
    logic lsb;
    c = PORT_CFG_RESET;
    lsb = b[CFG_LSB_HI] | b[CFG_LSB_LO];
    c[CFG_LSB_HI] = lsb;
    c[CFG_LSB_LO] = lsb;
    c[CFG_SOFT_RST] = b[CFG_SOFT_RST];
    c[CFG_DEV_RST] = b[CFG_DEV_RST];
    return c;
  endfunction

  // byte returned for a read of one address
  function automatic logic [7:0] read_byte(input scp_regs_t s,
                                           input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = BYTE_ZERO;
    if (a == ADDR_PORT_CFG)
    begin
      // readback select picks buffered or in-use copy
      v = s.rb_active ? s.cfg_shadow : s.cfg_active;
    end
    else if (a == ADDR_READBACK)
    begin
      v[READBACK_SEL] = s.rb_active ? s.rb_shadow : s.rb_active;
    end
    // update register is self-clearing, so it always reads zero
    return v;
  endfunction

  // next-state logic for engine and registers
  always_comb
  begin
    logic lsb;                 // bit order in force right now
    logic [INSTR_W-1:0] word;  // rx with the current bit merged
    logic [7:0] data_byte;     // completed data byte
    logic [ADDR_W-1:0] nxt_addr;
    lsb = 1'b0;
    word = '0;
    data_byte = BYTE_ZERO;
    nxt_addr = '0;
    r_next = r_reg;
    r_next.update_pulse = 1'b0;
    lsb = r_reg.cfg_active[CFG_LSB_HI];

    // soft reset acts once after an update, then clears itself
    if (r_reg.cfg_active[CFG_SOFT_RST])
    begin
      r_next.cfg_shadow = PORT_CFG_RESET;
      r_next.cfg_active = PORT_CFG_RESET;
      r_next.rb_shadow = READBACK_RESET[READBACK_SEL];
      r_next.rb_active = READBACK_RESET[READBACK_SEL];
    end

    if (lk.cs_n)
    begin
      // deselected: release the data line at once
      r_next.sdio_oe = 1'b0;
      // a rise off a byte boundary, or the end of a finished or
      // streaming cycle, returns the engine to instruction phase;
      // a rise on a boundary of a fixed-length cycle only stalls
      if ((r_reg.bit_cnt[2:0] != BYTE_PHASE_ZERO)
          || (r_reg.fsm == ST_DONE)
          || ((r_reg.fsm == ST_DATA) && r_reg.stream))
      begin
        r_next.fsm = ST_INSTR;
        r_next.bit_cnt = '0;
      end
    end
    else
    begin
      if (lk.sclk_rise)
      begin
        // write and instruction bits are sampled on the rising edge
        if (lsb)
        begin
          word = {lk.sdio_in, r_reg.rx[INSTR_W-1:1]};
        end
        else
        begin
          word = {r_reg.rx[INSTR_W-2:0], lk.sdio_in};
        end
        r_next.rx = word;
        r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
        data_byte = lsb ? word[INSTR_W-1:BYTE_W] : word[BYTE_W-1:0];
        // msb-first walks down, lsb-first walks up, no skipping
        nxt_addr = lsb ? (r_reg.addr + ADDR_STEP)
                       : (r_reg.addr - ADDR_STEP);

        unique case (r_reg.fsm)
          ST_INSTR:
          begin
            // sixteen bits always make the instruction word
            if (r_reg.bit_cnt == INSTR_LAST_BIT)
            begin
              r_next.fsm = ST_DATA;
              r_next.bit_cnt = '0;
              r_next.is_read = word[INSTR_RW_POS];
              r_next.stream =
                ({word[INSTR_LEN_HI], word[INSTR_LEN_LO]}
                 == LEN_STREAM);
              r_next.bytes_left = {word[INSTR_LEN_HI],
                                   word[INSTR_LEN_LO]};
              r_next.addr = word[ADDR_W-1:0];
              // first read byte comes from the given address
              r_next.tx = read_byte(r_reg, word[ADDR_W-1:0]);
            end
          end
          ST_DATA:
          begin
            if (r_reg.bit_cnt == BYTE_LAST_BIT)
            begin
              r_next.bit_cnt = '0;
              if (!r_reg.is_read)
              begin
                // writes reach only the shadow copies; read-only
                // and unmapped addresses drop the byte
                if (r_reg.addr == ADDR_PORT_CFG)
                begin
                  r_next.cfg_shadow = cfg_from_byte(data_byte);
                end
                else if (r_reg.addr == ADDR_READBACK)
                begin
                  r_next.rb_shadow = data_byte[READBACK_SEL];
                end
                else if ((r_reg.addr == ADDR_UPDATE)
                         && data_byte[UPDATE_BIT])
                begin
                  // strobe copies every pending change together
                  r_next.cfg_active = r_reg.cfg_shadow;
                  r_next.rb_active = r_reg.rb_shadow;
                  r_next.update_pulse = 1'b1;
                  // the soft reset request is consumed here
                  r_next.cfg_shadow[CFG_SOFT_RST] = 1'b0;
                end
              end
              // later bytes use the counter, not the instruction
              r_next.addr = nxt_addr;
              r_next.tx = read_byte(r_reg, nxt_addr);
              if (!r_reg.stream)
              begin
                r_next.bytes_left = r_reg.bytes_left - 1'b1;
                // count reached: ignore further clocks until deselect
                if (r_reg.bytes_left == 2'h0)
                begin
                  r_next.fsm = ST_DONE;
                end
              end
            end
          end
          ST_DONE:
          begin
            // cycle complete; extra clocks change only rx
            r_next.bit_cnt = r_reg.bit_cnt;
          end
        endcase
      end

      // read bits launch on the falling edge of the shift clock
      if (lk.sclk_fall && (r_reg.fsm == ST_DATA) && r_reg.is_read)
      begin
        r_next.sdio_oe = 1'b1;
        if (lsb)
        begin
          r_next.sdio_out = r_reg.tx[0];
          r_next.tx = {1'b0, r_reg.tx[BYTE_W-1:1]};
        end
        else
        begin
          r_next.sdio_out = r_reg.tx[BYTE_W-1];
          r_next.tx = {r_reg.tx[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end

  // single state register, synchronous reset to defaults
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r_reg.fsm <= ST_INSTR;
      r_reg.bit_cnt <= '0;
      r_reg.rx <= '0;
      r_reg.is_read <= 1'b0;
      r_reg.stream <= 1'b0;
      r_reg.bytes_left <= '0;
      r_reg.addr <= '0;
      r_reg.tx <= BYTE_ZERO;
      r_reg.sdio_out <= 1'b0;
      r_reg.sdio_oe <= 1'b0;
      r_reg.cfg_shadow <= PORT_CFG_RESET;
      r_reg.cfg_active <= PORT_CFG_RESET;  // msb-first after reset
      r_reg.rb_shadow <= READBACK_RESET[READBACK_SEL];
      r_reg.rb_active <= READBACK_RESET[READBACK_SEL];
      r_reg.update_pulse <= 1'b0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state record
  assign sdio_out = r_reg.sdio_out;
  assign sdio_oe = r_reg.sdio_oe;
  assign lsb_first_active = r_reg.cfg_active[CFG_LSB_HI];
  assign readback_shadow_active = r_reg.rb_active;
  assign device_reset_req = r_reg.cfg_active[CFG_DEV_RST];
  assign update_pulse = r_reg.update_pulse;

endmodule // scp_serial_port

`default_nettype wire

// >>> scp_serial_port_monitor.sv
// checker for the serial control port pins
// assumes: bound to scp_serial_port, all pins seen on clk_sys
`timescale 1ns/1ps
`default_nettype none

module scp_serial_port_monitor
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  // active settings
  input wire logic lsb_first_active,
  input wire logic readback_shadow_active,
  input wire logic device_reset_req,
  input wire logic update_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // synchroniser lag allows a few cycles before release
  AST_OE_RELEASE: assert property (cs_n [*6] |-> !sdio_oe)
    else $error("data line driven while deselected");
  AST_OE_IN_FRAME: assert property (
    $rose(sdio_oe) |-> !$past(cs_n, 3))
    else $error("drive started outside a frame");
  // a read bit moves only after a falling shift edge
  AST_OUT_AFTER_FALL: assert property (
    sdio_oe && $changed(sdio_out) |-> !$past(sclk, 2))
    else $error("read bit moved while shift clock high");
  AST_UPD_ONE_CYCLE: assert property (
    update_pulse |=> !update_pulse)
    else $error("update strobe longer than one cycle");
  AST_UPD_IN_FRAME: assert property (
    update_pulse |-> !$past(cs_n, 3))
    else $error("update strobe without a frame");
  AST_NO_OE_AT_UPDATE: assert property (update_pulse |-> !sdio_oe)
    else $error("line driven during a write");
  // active copies move only around an update strobe
  AST_LSB_ON_UPDATE: assert property (
    $changed(lsb_first_active) |->
      update_pulse || $past(update_pulse) || $past(update_pulse, 2))
    else $error("bit order changed without update");
  AST_RB_ON_UPDATE: assert property (
    $changed(readback_shadow_active) |->
      update_pulse || $past(update_pulse) || $past(update_pulse, 2))
    else $error("readback select changed without update");

  // main scenarios
  COV_UPDATE: cover property (update_pulse);
  COV_READ: cover property ($rose(sdio_oe));
  COV_LSB: cover property ($rose(lsb_first_active));
endmodule // scp_serial_port_monitor

`default_nettype wire

// >>> scp_host_model.sv
// host model that frames and shifts control port transfers
// assumes: clk_sys at 25 ns, shift clock built from 4+4 cycles
`timescale 1ns/1ps
`default_nettype none

module scp_host_model
(
  // clock
  input wire logic clk_sys,
  // device side of the shared line
  input wire logic dut_out,
  input wire logic dut_oe,
  // host pins
  output var logic sclk,
  output var logic cs_n,
  output logic sdio_line
);
  logic host_d; // host bit, toggles once released so no stale level

  // idle: select high, clock driven low by the model
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_d = 1'b0;
  end

  // device wins the line while it drives
  assign sdio_line = dut_oe ? dut_out : host_d;

  // one shift clock: change on low, device takes on rise
  task automatic shift_bit(input logic b, input logic drv, output logic r);
    @(posedge clk_sys);
    sclk <= 1'b0;
    host_d <= drv ? b : ~host_d;
    repeat (4) @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    r = sdio_line; // read bit settled since the fall
    @(posedge clk_sys);
  endtask

  // whole frame; n below zero cuts the instruction mid-byte
  task automatic xfer(input logic lsb, input logic [15:0] ins, input int n,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    int i;
    int k;
    int p;
    rd = '0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < (n < 0 ? 5 : 16); i++)
      shift_bit(ins[lsb ? i : 15 - i], 1'b1, r);
    for (k = 0; k < n; k++)
      for (i = 0; i < 8; i++)
      begin
        p = 8 * k + (lsb ? i : 7 - i);
        shift_bit(wd[p], !ins[15], r);
        rd[p] = r;
      end
    @(posedge clk_sys);
    sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // scp_host_model

`default_nettype wire

// >>> scp_serial_port_tb.sv
// self-checking bench for the serial control port
// assumes: host model drives the pins, checker bound below
`timescale 1ns/1ps
`default_nettype none

module scp_serial_port_tb;
  import scp_pkg::*;
  // one frame and what it should leave behind
  typedef struct {
    logic lsb;
    logic [15:0] ins;
    int n;
    logic [31:0] wd;
    logic [31:0] exp;
    logic exp_lsb;
    logic exp_rb;
  } scp_row_t;

  logic clk_sys, rst, sclk, cs_n, sdio_line, sdio_out, sdio_oe;
  logic lsb_act, rb_act, dev_rst, upd;
  int err_total = 0;
  int cmp_count = 0;
  int pulses = 0; // update strobes seen
  logic [31:0] rd;
  scp_row_t rows [14] = '{
    '{0, 16'h8000, 1, 0, 32'h18, 0, 0}, // reset value of config
    '{0, 16'h8005, 1, 0, 32'h00, 0, 0}, // update reads zero
    '{0, 16'h0010, 1, 32'h00, 0, 0, 0}, // unmapped, zeros only
    '{0, 16'h8010, 1, 0, 32'h00, 0, 0}, // unmapped read
    '{0, 16'h0004, 1, 32'h01, 0, 0, 0}, // shadow only
    '{0, 16'h8004, 1, 0, 32'h00, 0, 0}, // active copy read
    '{0, 16'h0005, 1, 32'h01, 0, 0, 1}, // update
    '{0, 16'hc005, 3, 0, 32'h000100, 0, 1}, // 5,4,3 downward
    '{0, 16'h0000, 1, 32'h02, 0, 0, 1}, // lower order bit only
    '{0, 16'h0005, 1, 32'h01, 0, 1, 1}, // order switches
    '{1, 16'he000, 4, 0, 32'h5a, 1, 1}, // stream 0,1,2,3 upward
    '{1, 16'h0000, 1, 32'h20, 0, 1, 1}, // soft reset queued
    '{1, 16'h0005, 1, 32'h01, 0, 0, 0}, // soft reset acts
    '{0, 16'h8000, 1, 0, 32'h18, 0, 0}}; // back to defaults

  scp_serial_port scp_serial_port_i (.clk_sys(clk_sys), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_line), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .lsb_first_active(lsb_act),
    .readback_shadow_active(rb_act), .device_reset_req(dev_rst),
    .update_pulse(upd));

  scp_host_model scp_host_model_i (.clk_sys(clk_sys), .dut_out(sdio_out),
    .dut_oe(sdio_oe), .sclk(sclk), .cs_n(cs_n), .sdio_line(sdio_line));

  // 40 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // count update strobes
  always @(posedge clk_sys)
    if (upd === 1'b1)
      pulses <= pulses + 1;

  // compare and report
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask

  // single closing point
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    test_done();
  end

  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("lsb_first_active", 0, lsb_act);
    chk("sdio_oe", 0, sdio_oe);
    foreach (rows[j])
    begin
      scp_host_model_i.xfer(rows[j].lsb, rows[j].ins, rows[j].n,
                            rows[j].wd, rd);
      if (rows[j].ins[15])
        chk("read data", rows[j].exp, rd);
      chk("lsb_first_active", rows[j].exp_lsb, lsb_act);
      chk("readback_shadow_active", rows[j].exp_rb, rb_act);
    end
    // rows 6, 9 and 12 each carry one update byte
    chk("update strobes", 3, pulses);
    // device reset bit reaches its output only after an update
    scp_host_model_i.xfer(0, 16'h0000, 1, 32'h04, rd);
    chk("device_reset_req", 0, dev_rst);
    scp_host_model_i.xfer(0, 16'h0005, 1, 32'h01, rd);
    chk("device_reset_req", 1, dev_rst);
    scp_host_model_i.xfer(0, 16'h8000, 1, 0, rd);
    chk("read data", 32'h1c, rd);
    chk("update strobes", 4, pulses);
    // reset in mid-run, select high and shift clock low meanwhile
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("device_reset_req", 0, dev_rst);
    chk("lsb_first_active", 0, lsb_act);
    chk("readback_shadow_active", 0, rb_act);
    // read frame cut after five bits must leave the port idle
    scp_host_model_i.xfer(0, 16'hffff, -1, 0, rd);
    chk("sdio_oe after cut", 0, sdio_oe);
    // the next whole frame must decode from a clean start
    scp_host_model_i.xfer(0, 16'h8000, 1, 0, rd);
    chk("read after cut", 32'h18, rd);
    test_done();
  end
endmodule // scp_serial_port_tb

bind scp_serial_port scp_serial_port_monitor scp_serial_port_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .lsb_first_active(lsb_first_active),
  .readback_shadow_active(readback_shadow_active),
  .device_reset_req(device_reset_req), .update_pulse(update_pulse));

`default_nettype wire
